// ---- verilog/fsg_flash_host.sv ----
/*
 * Host-side controller for an asynchronous parallel flash: single writes,
 * reads, toggle-bit polling and extra sector erase commands, steered by
 * software over an AHB-Lite slave. Assumes one slave on the bus, a pulled-up
 * ready/busy line and that the board resolves the data pins from dq_oe_n.
 */
// The AHB-Lite interface to the registers and the register offsets were left to the implementer.
`default_nettype none
module fsg_flash_host (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic en,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output fsg_pkg::fsg_pins_s fl_pins,
    input wire logic [15:0] dq_in,
    input wire logic ready_busy_output
);
    import fsg_pkg::*;

    typedef enum logic [2:0] {
        S_IDLE, S_WLOW, S_WHIGH, S_RLOW, S_RHIGH, S_NEXT
    } fsg_state_e;

    fsg_state_e state_q, state_d;
    logic [3:0] cnt_q, cnt_d;
    logic [2:0] step_q, step_d;
    logic [2:0] op_q, op_d;
    logic cmd_q, cmd_d;
    logic prev_q, prev_d;
    logic [15:0] wout_q, wout_d;
    logic [15:0] rdata_q, rdata_d;
    logic done_q, done_d;
    logic fail_q, fail_d;
    logic nacc_q, nacc_d;
    logic [FL_AW:0] addr_q, addr_d;
    logic [15:0] wdata_q, wdata_d;
    logic [2:0] cfg_q, cfg_d;
    logic wr_ph_q, wr_ph_d;
    logic [7:0] ad_ph_q, ad_ph_d;
    logic [31:0] hrdata_q, hrdata_d;
    fsg_pins_s pins_q, pins_d;
    logic [16:0] s1_q, s2_q, s3_q, filt_q, filt_d;

    logic go, go_wr, go_rd, finish, tb_now;
    logic [2:0] go_op;
    logic [ST_W:0] stat;

    assign hreadyout = 1'b1 & hresetn | 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign fl_pins = pins_q;

    always_comb begin
        // A bit counts only once the second and third stages agree
        filt_d = (~(s2_q ^ s3_q) & s2_q) | ((s2_q ^ s3_q) & filt_q);

        stat = '0;
        stat[ST_BUSY] = (state_q != S_IDLE);
        stat[ST_RYBY] = filt_q[16];
        stat[ST_DONE] = done_q;
        stat[ST_FAIL] = fail_q;
        stat[ST_NACC] = nacc_q;
        stat[ST_W] = rdata_q[DQ_B5];

        wr_ph_d = wr_ph_q;
        ad_ph_d = ad_ph_q;
        hrdata_d = hrdata_q;
        if (hready) begin
            wr_ph_d = hsel & htrans[1] & hwrite;
            ad_ph_d = haddr[7:0];
            if (hsel && htrans[1] && !hwrite) begin
                case (haddr[7:0])
                    REG_CTRL: hrdata_d = 32'(op_q);
                    REG_ADDR: hrdata_d = 32'(addr_q);
                    REG_WDATA: hrdata_d = 32'(wdata_q);
                    REG_RDATA: hrdata_d = 32'(rdata_q);
                    REG_STATUS: hrdata_d = 32'(stat);
                    REG_CFG: hrdata_d = 32'(cfg_q);
                    default: hrdata_d = '0;
                endcase
            end
        end

        addr_d = addr_q;
        wdata_d = wdata_q;
        cfg_d = cfg_q;
        go = 1'b0;
        go_op = OP_NONE;
        if (wr_ph_q) begin
            case (ad_ph_q)
                REG_CTRL: begin
                    go = 1'b1;
                    go_op = hwdata[2:0];
                end
                REG_ADDR: addr_d = hwdata[FL_AW:0];
                REG_WDATA: wdata_d = hwdata[15:0];
                REG_CFG: cfg_d = hwdata[2:0];
                default: ;
            endcase
        end

        state_d = state_q;
        cnt_d = cnt_q;
        step_d = step_q;
        op_d = op_q;
        cmd_d = cmd_q;
        prev_d = prev_q;
        wout_d = wout_q;
        rdata_d = rdata_q;
        done_d = done_q;
        fail_d = fail_q;
        nacc_d = nacc_q;
        go_wr = 1'b0;
        go_rd = 1'b0;
        finish = 1'b0;
        tb_now = cfg_q[CFG_TSEL] ? rdata_q[DQ_B2] : rdata_q[DQ_B6];

        case (state_q)
            S_IDLE: begin
                // Every start runs the whole sequence from step zero
                if (go && go_op != OP_NONE && go_op != OP_ABORT) begin
                    op_d = go_op;
                    cmd_d = hwdata[CTRL_CMD];
                    step_d = '0;
                    done_d = 1'b0;
                    fail_d = 1'b0;
                    nacc_d = 1'b0;
                    wout_d = wdata_q;
                    go_wr = (go_op == OP_WRITE);
                    go_rd = (go_op != OP_WRITE);
                end
            end
            S_WLOW: begin
                if (cnt_q == '0) begin
                    state_d = S_WHIGH;
                    cnt_d = 4'(WPH_CYC - 1);
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            S_RLOW: begin
                if (cnt_q == '0) begin
                    rdata_d = filt_q[15:0];
                    state_d = S_RHIGH;
                    cnt_d = 4'(OEH_CYC - 1);
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            S_WHIGH, S_RHIGH: begin
                if (cnt_q == '0) begin
                    state_d = S_NEXT;
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            S_NEXT: begin
                case (op_q)
                    OP_POLL: begin
                        case (step_q)
                            3'h0, 3'h2: begin
                                prev_d = tb_now;
                                go_rd = 1'b1;
                                step_d = step_q + 3'h1;
                            end
                            3'h1: begin
                                if (tb_now == prev_q) begin
                                    finish = 1'b1;
                                end else if (rdata_q[DQ_B5]) begin
                                    go_rd = 1'b1;
                                    step_d = 3'h2;
                                end else begin
                                    prev_d = tb_now;
                                    go_rd = 1'b1;
                                end
                            end
                            3'h3: begin
                                if (tb_now == prev_q) begin
                                    finish = 1'b1;
                                end else begin
                                    // Failed operation: return device to read
                                    fail_d = 1'b1;
                                    cmd_d = 1'b1;
                                    wout_d = RESET_CMD;
                                    go_wr = 1'b1;
                                    step_d = 3'h4;
                                end
                            end
                            default: finish = 1'b1;
                        endcase
                    end
                    OP_SECT: begin
                        case (step_q)
                            3'h0: begin
                                // Window already closed: command would be lost
                                if (rdata_q[DQ_B3]) begin
                                    nacc_d = 1'b1;
                                    finish = 1'b1;
                                end else begin
                                    cmd_d = 1'b1;
                                    go_wr = 1'b1;
                                    step_d = 3'h1;
                                end
                            end
                            3'h1: begin
                                go_rd = 1'b1;
                                step_d = 3'h2;
                            end
                            default: begin
                                nacc_d = rdata_q[DQ_B3];
                                finish = 1'b1;
                            end
                        endcase
                    end
                    default: finish = 1'b1;
                endcase
            end
            default: state_d = S_IDLE;
        endcase

        if (go_wr) begin
            state_d = S_WLOW;
            cnt_d = 4'(WP_CYC - 1);
        end
        if (go_rd) begin
            state_d = S_RLOW;
            cnt_d = 4'(RD_CYC - 1);
        end
        if (finish) begin
            state_d = S_IDLE;
            done_d = 1'b1;
        end
        // Abort may cut a strobe short; the device still latches on its early rising edge
        if (go && go_op == OP_ABORT) begin
            state_d = S_IDLE;
        end

        pins_d.rst_n = cfg_q[CFG_RUN];
        pins_d.width_sel = cfg_q[CFG_WORD];
        pins_d.addr = cfg_q[CFG_WORD] ? addr_q[FL_AW-1:0] : addr_q[FL_AW:1];
        // Strobes follow state only: write never overlaps a read strobe
        pins_d.ce_n = !(state_d == S_WLOW || state_d == S_RLOW);
        pins_d.we_n = !(state_d == S_WLOW);
        pins_d.oe_n = !(state_d == S_RLOW);
        pins_d.dq_o = wout_d;
        pins_d.dq_oe_n = '1;
        if (!cfg_q[CFG_WORD]) begin
            pins_d.dq_o[15:8] = '0;
            pins_d.dq_o[DQ_TOP] = addr_q[0];
            pins_d.dq_oe_n[DQ_TOP] = 1'b0;
        end
        if (state_d == S_WLOW || state_d == S_WHIGH) begin
            pins_d.dq_oe_n[7:0] = '0;
            if (cfg_q[CFG_WORD] && !cmd_d) begin
                pins_d.dq_oe_n[15:8] = '0;
            end else if (cfg_q[CFG_WORD]) begin
                pins_d.dq_oe_n[15:8] = '1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= S_IDLE;
            cnt_q <= '0;
            step_q <= '0;
            op_q <= OP_NONE;
            cmd_q <= 1'b0;
            prev_q <= 1'b0;
            wout_q <= '0;
            rdata_q <= '0;
            done_q <= 1'b0;
            fail_q <= 1'b0;
            nacc_q <= 1'b0;
            addr_q <= '0;
            wdata_q <= '0;
            cfg_q <= CFG_RESET;
            wr_ph_q <= 1'b0;
            ad_ph_q <= '0;
            hrdata_q <= '0;
            pins_q <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rst_n: 1'b0,
                        width_sel: 1'b1, addr: '0, dq_o: '0, dq_oe_n: '1};
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            filt_q <= '0;
        end else if (en) begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            step_q <= step_d;
            op_q <= op_d;
            cmd_q <= cmd_d;
            prev_q <= prev_d;
            wout_q <= wout_d;
            rdata_q <= rdata_d;
            done_q <= done_d;
            fail_q <= fail_d;
            nacc_q <= nacc_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            cfg_q <= cfg_d;
            wr_ph_q <= wr_ph_d;
            ad_ph_q <= ad_ph_d;
            hrdata_q <= hrdata_d;
            pins_q <= pins_d;
            s1_q <= {ready_busy_output, dq_in};
            s2_q <= s1_q;
            s3_q <= s2_q;
            filt_q <= filt_d;
        end
    end
endmodule
`default_nettype wire

// ---- include/fsg_pkg.sv ----
/*
 * Constants, register map and pin bundle of the flash status host.
 * Assumes a 40 MHz hclk; all pin timing is derived from it here.
 */
`default_nettype none
package fsg_pkg;
    localparam int FL_AW = 19;
    localparam int CLK_NS = 25;
    localparam int T_WP_NS = 45;
    localparam int T_WPH_NS = 25;
    localparam int T_ACC_NS = 90;
    localparam int T_OEH_NS = 10;
    localparam int SYNC_LAT = 4;
    localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int WPH_CYC = (T_WPH_NS + CLK_NS - 1) / CLK_NS;
    localparam int RD_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_LAT;
    localparam int OEH_CYC = (T_OEH_NS + CLK_NS - 1) / CLK_NS;

    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_RDATA = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_CFG = 8'h14;

    localparam int CTRL_CMD = 3;
    localparam logic [2:0] OP_NONE = 3'h0;
    localparam logic [2:0] OP_WRITE = 3'h1;
    localparam logic [2:0] OP_READ = 3'h2;
    localparam logic [2:0] OP_POLL = 3'h3;
    localparam logic [2:0] OP_SECT = 3'h4;
    localparam logic [2:0] OP_ABORT = 3'h5;

    localparam int CFG_WORD = 0;
    localparam int CFG_TSEL = 1;
    localparam int CFG_RUN = 2;
    localparam logic [2:0] CFG_RESET = 3'h5;

    localparam int ST_BUSY = 0;
    localparam int ST_RYBY = 1;
    localparam int ST_DONE = 2;
    localparam int ST_FAIL = 3;
    localparam int ST_NACC = 4;
    localparam int ST_W = 5;

    localparam int DQ_B2 = 2;
    localparam int DQ_B3 = 3;
    localparam int DQ_B5 = 5;
    localparam int DQ_B6 = 6;
    localparam int DQ_TOP = 15;
    localparam logic [15:0] RESET_CMD = 16'h00f0;

    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic rst_n;
        logic width_sel;
        logic [FL_AW-1:0] addr;
        logic [15:0] dq_o;
        logic [15:0] dq_oe_n;
    } fsg_pins_s;
endpackage
`default_nettype wire

// ---- test/fsg_flash_host_asserts.sv ----
/* Checker of the flash host's bus answers and pin sequencing.
   Assumes the top ports only; bound to fsg_flash_host below. */
`default_nettype none
module fsg_flash_host_asserts (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire fsg_pkg::fsg_pins_s fl_pins
);
    timeunit 1ns;
    timeprecision 100ps;
    import fsg_pkg::*;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    sequence wr_pulse_s;
        !fl_pins.we_n [*2] ##1 fl_pins.we_n;
    endsequence
    sequence rd_pulse_s;
        $fell(fl_pins.oe_n) ##1 !fl_pins.oe_n [*7];
    endsequence
    write_inhibit_a: assert property (
        !fl_pins.we_n |-> !fl_pins.ce_n && fl_pins.oe_n)
        else $error("write strobe without select or with read strobe");
    strobe_idle_a: assert property (
        fl_pins.ce_n |-> fl_pins.we_n && fl_pins.oe_n)
        else $error("strobe active while chip deselected");
    write_width_a: assert property ($fell(fl_pins.we_n) |-> wr_pulse_s)
        else $error("write pulse length wrong");
    // An abort may end a read early, so only a full read is timed
    read_width_a: assert property (rd_pulse_s |=> fl_pins.oe_n)
        else $error("read pulse too long");
    write_hold_a: assert property (
        !fl_pins.we_n |=> $stable(fl_pins.dq_o) && $stable(fl_pins.addr))
        else $error("write data or address moved in a write");
    cmd_lane_a: assert property (
        !fl_pins.we_n |-> fl_pins.dq_oe_n[7:0] == 8'h00)
        else $error("low data byte not driven in a write");
    read_release_a: assert property (
        !fl_pins.oe_n |-> fl_pins.dq_oe_n[7:0] == 8'hff)
        else $error("host drives data while reading");
    byte_mode_a: assert property (
        !fl_pins.width_sel && !$past(fl_pins.width_sel)
        |-> fl_pins.dq_oe_n[15:8] == 8'h7f)
        else $error("byte mode lanes wrong");
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("slave not ready or not okay");
endmodule
bind fsg_flash_host fsg_flash_host_asserts i_chk (
    .hclk(hclk),
    .hresetn(hresetn),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .fl_pins(fl_pins)
);
`default_nettype wire

// ---- test/fsg_flash_model.sv ----
/* Behavioural flash device: status bits, write latch, ready/busy.
   Assumes mode and window flag are set by the bench. */
`default_nettype none
module fsg_flash_model (
    input wire logic hclk,
    input wire fsg_pkg::fsg_pins_s fl_pins,
    input wire logic [1:0] mode,
    input wire logic win_open,
    output logic [15:0] dq_in,
    output logic ready_busy_output
);
    timeunit 1ns;
    timeprecision 100ps;
    import fsg_pkg::*;
    logic tgl = 1'b0;
    logic [15:0] dq_last = 16'h0;
    logic [15:0] lat_d = 16'h0;
    logic [7:0] last_cmd = 8'h0;
    logic [15:0] stat;
    int wr_count = 0;
    logic wr_act;
    // Top sector of the array is marked protected
    localparam logic [2:0] PROT_SECT = 3'h7;
    // Write ends on whichever of select or strobe rises first
    assign wr_act = !fl_pins.ce_n && !fl_pins.we_n && fl_pins.oe_n;
    // Modes: 0 array, 1 erase, 2 suspended read, 3 stuck program
    always @(negedge wr_act) begin
        // Held reset stands in for supply lockout: writes are ignored
        if (fl_pins.rst_n) begin
            if ((mode != 2'd1 || win_open)
                    && fl_pins.addr[FL_AW-1 -: 3] != PROT_SECT) begin
                lat_d = dq_in;
                last_cmd = dq_in[7:0];
                wr_count++;
            end
        end
    end
    always @(posedge fl_pins.oe_n) tgl = ~tgl;
    always_comb begin
        case (mode)
            2'd1: stat = {9'h0, tgl, 2'b00, ~win_open, tgl, 2'b00};
            2'd2: stat = {8'h0, 2'b11, 3'b000, tgl, 2'b00};
            2'd3: stat = {9'h0, tgl, 3'b100, 1'b1, 2'b00};
            default: stat = 16'h3c96;
        endcase
    end
    // Released lines show a moving pattern, never the last value
    always @(posedge hclk) dq_last <= dq_in;
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            if (!fl_pins.dq_oe_n[i]) dq_in[i] = fl_pins.dq_o[i];
            else if (!fl_pins.ce_n && !fl_pins.oe_n && (fl_pins.width_sel || i < 8))
                dq_in[i] = stat[i];
            else dq_in[i] = ~dq_last[i];
        end
    end
    // Busy follows mode: it stands for the state after the last pulse
    assign ready_busy_output = fl_pins.rst_n && mode != 2'd1
        && mode != 2'd3;
endmodule
`default_nettype wire

// ---- test/fsg_flash_host_tb_top.sv ----
/* Bench: drives the host over AHB-Lite against the flash model.
   Assumes the register map of the package; waits on hready. */
`default_nettype none
module fsg_flash_host_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import fsg_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, ryby, win_open;
    logic [1:0] htrans, mode;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [15:0] dq;
    fsg_pins_s pins;
    int errors, checks_done, n0;
    logic [1:0] pm [3] = '{2'd2, 2'd0, 2'd3};
    logic pt [3] = '{1'b0, 1'b1, 1'b0};
    logic [31:0] pe [3] = '{32'h4, 32'h4, 32'h2c};
    logic [1:0] rm [3] = '{2'd1, 2'd2, 2'd2};
    logic [31:0] rc [3] = '{32'h7, 32'h7, 32'h3};
    fsg_flash_host i_dut (.hclk(hclk), .hresetn(hresetn), .en(1'b1),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .fl_pins(pins), .dq_in(dq), .ready_busy_output(ryby));
    fsg_flash_model i_dev (.hclk(hclk), .fl_pins(pins), .mode(mode),
        .win_open(win_open), .dq_in(dq), .ready_busy_output(ryby));
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    task automatic give_verdict();
        $display("errors=%0d checks_done=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Single word transfer; waits on hready with a bound
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 100);
        q = hrdata;
        if (n >= 100) begin
            errors++;
            give_verdict();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d, rd);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
        ahb(1'b0, a, 32'h0, rd);
        chk(rd & m, e);
    endtask
    task automatic wait_idle(input int lim);
        int k;
        k = 0;
        do begin ahb(1'b0, REG_STATUS, 32'h0, rd); k++; end
        while (rd[ST_BUSY] !== 1'b0 && k < lim);
        if (rd[ST_BUSY] !== 1'b0) begin
            errors++;
            give_verdict();
        end
    endtask
    initial begin
        hresetn = 1'b0;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        mode = 2'd0;
        win_open = 1'b1;
        errors = 0;
        checks_done = 0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdc(REG_CFG, 32'hffffffff, {29'h0, CFG_RESET});
        rdc(8'h20, 32'hffffffff, 32'h0);
        wr(REG_ADDR, 32'h123);
        wr(REG_WDATA, 32'ha5c3);
        wr(REG_CTRL, {29'h0, OP_WRITE});
        wait_idle(50);
        chk({16'h0, i_dev.lat_d}, 32'ha5c3);
        wr(REG_WDATA, 32'h12a5);
        wr(REG_CTRL, {28'h0, 1'b1, OP_WRITE});
        wait_idle(50);
        chk({24'h0, i_dev.last_cmd}, 32'ha5);
        wr(REG_CTRL, {29'h0, OP_READ});
        wait_idle(50);
        rdc(REG_RDATA, 32'hffff, 32'h3c96);
        // Steady, settled and failing toggle polls
        for (int i = 0; i < 3; i++) begin
            mode <= pm[i];
            wr(REG_CFG, {29'h0, 1'b1, pt[i], 1'b1});
            wr(REG_CTRL, {29'h0, OP_POLL});
            wait_idle(300);
            rdc(REG_STATUS, 32'h2c, pe[i]);
        end
        chk({24'h0, i_dev.last_cmd}, 32'hf0);
        mode <= 2'd2;
        wr(REG_CFG, 32'h7);
        wr(REG_CTRL, {29'h0, OP_POLL});
        repeat (60) @(posedge hclk);
        rdc(REG_STATUS, 32'h5, 32'h1);
        wr(REG_CTRL, {29'h0, OP_ABORT});
        mode <= 2'd0;
        wr(REG_CTRL, {29'h0, OP_POLL});
        wait_idle(300);
        rdc(REG_STATUS, 32'hc, 32'h4);
        for (int i = 0; i < 3; i++) begin
            mode <= rm[i];
            wr(REG_CFG, rc[i]);
            repeat (8) @(posedge hclk);
            rdc(REG_STATUS, 32'h2, {30'h0, i == 1, 1'b0});
        end
        wr(REG_CFG, 32'h7);
        mode <= 2'd1;
        n0 = i_dev.wr_count;
        // Open window accepts, closed window refuses
        for (int i = 0; i < 2; i++) begin
            win_open <= (i == 0);
            wr(REG_ADDR, 32'h8000);
            wr(REG_WDATA, 32'h30);
            wr(REG_CTRL, {29'h0, OP_SECT});
            wait_idle(300);
            rdc(REG_STATUS, 32'h10, {27'h0, i == 1, 4'h0});
            chk(32'(i_dev.wr_count), 32'(n0 + 1));
        end
        mode <= 2'd0;
        wr(REG_CFG, 32'h4);
        wr(REG_ADDR, 32'h7);
        wr(REG_WDATA, 32'h44);
        wr(REG_CTRL, {29'h0, OP_WRITE});
        wait_idle(50);
        chk({23'h0, i_dev.lat_d[15], i_dev.lat_d[7:0]}, 32'h144);
        chk({13'h0, pins.addr}, 32'h3);
        // Protected top sector keeps the earlier latched byte
        wr(REG_ADDR, 32'he0000);
        wr(REG_WDATA, 32'h55);
        wr(REG_CTRL, {29'h0, OP_WRITE});
        wait_idle(50);
        chk({24'h0, i_dev.lat_d[7:0]}, 32'h44);
        give_verdict();
    end
endmodule
`default_nettype wire
